// ### pkg/lbd_pkg.sv
package lbd_pkg;
    // Core clock and timing figures
    localparam int  CLK_MHZ       = 250;
    localparam real OFF_TIME_MS   = 2.5;
    localparam int  WIN_TIME_MS   = 1;
    localparam int  DLY_TIME_US   = 100;
    localparam int  DET_TIME_US   = 260;
    localparam int  START_TIME_US = 3;
    localparam int  BIT_MAX_US    = 180;
    localparam int  LOW_MAX_US    = 360;
    localparam int  SS_TIME_US    = 512;
    localparam int  MIN_ON_NS     = 40;
    localparam int  OSC_KHZ       = 1200;
    localparam int  MAX_DUTY_PCT  = 90;

    localparam int OFF_CYC_DEF = int'(OFF_TIME_MS * 1000.0 * CLK_MHZ);
    localparam int WIN_CYC_DEF = WIN_TIME_MS * 1000 * CLK_MHZ;
    localparam int DLY_CYC_DEF = DLY_TIME_US * CLK_MHZ;
    localparam int DET_CYC_DEF = DET_TIME_US * CLK_MHZ;
    localparam int MIN_CYC     = START_TIME_US * CLK_MHZ;
    localparam int BIT_CYC_DEF = BIT_MAX_US * CLK_MHZ;
    localparam int LOW_CYC_DEF = LOW_MAX_US * CLK_MHZ;
    localparam int SS_CYC_DEF  = SS_TIME_US * CLK_MHZ;
    localparam int MIN_ON_CYC  = (MIN_ON_NS * CLK_MHZ + 999) / 1000;
    localparam int OSC_CYC     = CLK_MHZ * 1000 / OSC_KHZ;
    localparam int MAX_ON_CYC  = OSC_CYC * MAX_DUTY_PCT / 100;

    localparam int CW = 20;
    localparam int RW = 17;

    // One-wire command
    localparam logic [7:0] DEV_ADDR  = 8'h72;
    localparam logic [4:0] STEP_FULL = 5'h1f;
    localparam int         STEP_W    = 5;

    // Register map, byte addresses
    localparam logic [3:0] REG_STATUS_OFS = 4'h0;
    localparam logic [3:0] REG_CTRL_OFS   = 4'h4;
    localparam logic [1:0] CTRL_RESET     = 2'h1;

    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_DET = 5'h02,
        ST_PWM = 5'h04,
        ST_DIG = 5'h08,
        ST_FLT = 5'h10
    } lbd_state_t;

    typedef struct packed {
        logic input_undervoltage_flag;
        logic otp;
        logic output_overvoltage_flag;
        logic switch_current_limit_flag;
    } lbd_fault_t;

    typedef struct packed {
        logic       byteDone;
        logic       abort;
        logic [7:0] data;
    } lbd_bit_t;
endpackage

// ### hdl/lbd_bit_rx.sv
`timescale 1ns/10ps
module lbd_bit_rx import lbd_pkg::*; #(
    parameter int BIT_CYC = BIT_CYC_DEF,
    parameter int LOW_CYC = LOW_CYC_DEF
) (
    input  wire logic     clk,    // Core clock
    input  wire logic     reset,  // Sync reset
    input  wire logic     run,    // Digital mode active
    input  wire logic     line,   // Synchronised enable level
    output lbd_bit_t      rx      // Byte and abort pulses
);
    logic          lineD;
    logic [RW-1:0] cnt;
    logic [RW-1:0] lowT;
    logic [3:0]    bitCnt;
    logic          inByte;
    logic          isOne;
    logic          isZero;
    logic          fall;
    logic          rise;

    assign fall = lineD & ~line;
    assign rise = ~lineD & line;

    // Ratio test on the closing falling edge; cnt holds the high time
    always_comb begin
        isOne  = lowT >= RW'(MIN_CYC) && lowT <= RW'(BIT_CYC)
              && {1'b0, cnt} >= {lowT, 1'b0} && cnt <= RW'(LOW_CYC);
        isZero = cnt >= RW'(MIN_CYC) && cnt <= RW'(BIT_CYC)
              && {1'b0, lowT} >= {cnt, 1'b0} && lowT <= RW'(LOW_CYC);
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (reset) begin
            lineD <= 1'b0;
            cnt   <= '0;
        end else begin
            lineD <= line;
            if (fall || rise)
                cnt <= '0;
            else if (cnt <= RW'(LOW_CYC))
                cnt <= cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (reset || !run) begin
            inByte <= 1'b0;
            bitCnt <= '0;
            lowT   <= '0;
            rx     <= '0;
        end else begin
            rx.byteDone <= 1'b0;
            rx.abort    <= 1'b0;
            if (rise)
                lowT <= cnt;
            if (inByte && cnt > RW'(LOW_CYC)) begin
                // A stuck level ends the byte; the host restarts with a start
                inByte   <= 1'b0;
                rx.abort <= 1'b1;
            end else if (rise && inByte && bitCnt == 4'h9) begin
                inByte <= 1'b0;
                if (cnt >= RW'(MIN_CYC))
                    rx.byteDone <= 1'b1;
                else
                    rx.abort <= 1'b1;
            end else if (fall && !inByte) begin
                // Start fall also opens the first bit, so count it now
                if (cnt >= RW'(MIN_CYC)) begin
                    inByte  <= 1'b1;
                    bitCnt  <= 4'h1;
                    rx.data <= '0;
                end
            end else if (fall && inByte) begin
                // Falling edge closes the previous bit
                if (isOne || isZero) begin
                    rx.data <= {rx.data[6:0], isOne};
                    bitCnt  <= bitCnt + 1'b1;
                end else begin
                    inByte   <= 1'b0;
                    rx.abort <= 1'b1;
                end
            end
        end
    end
endmodule

// ### hdl/lbd_core.sv
`timescale 1ns/10ps
// What this block does
// - Enable low over 2.5 ms shuts down
// - Mode picked at enable, PWM by default
// - Entry pattern only on start from shutdown
// - Entry uses 1 ms window, 100/260 us
// - High at least 3 us starts a byte
// - Byte closed by 3-360 us stream end
// - Zero bit: low at least twice high
// - One bit: high at least twice low
// - Digital mode gives 32 brightness steps
// - PWM mode chops reference with enable duty
// - Oscillator sets switch, comparator clears it
// - Switch stays on at least 40 ns
// - Current limit ends on-time this cycle
// - Over-voltage shuts driver down
// - Over-temperature pauses switching until cooled
// - Undervoltage turns driver off
// - Reference ramps up on every start from shutdown
// - Low then high inside window enters digital
// - Selected mode kept until next shutdown
// - Address 72 hex then data, MSB first
// - Bits timed falling edge to falling edge
module lbd_core import lbd_pkg::*; #(
    parameter int OFF_CYC = OFF_CYC_DEF,
    parameter int WIN_CYC = WIN_CYC_DEF,
    parameter int DLY_CYC = DLY_CYC_DEF,
    parameter int DET_CYC = DET_CYC_DEF,
    parameter int BIT_CYC = BIT_CYC_DEF,
    parameter int LOW_CYC = LOW_CYC_DEF,
    parameter int SS_CYC  = SS_CYC_DEF
) (
    input  wire logic              clk,              // 250 MHz core clock
    input  wire logic              reset,            // Sync reset, power-up or supply
    input  wire logic              enablePin,        // Enable pin, asynchronous
    input  wire lbd_fault_t        faultPins,        // Analog fault flags, asynchronous
    input  wire logic              currentTrip,      // Current comparator, asynchronous
    input  wire logic [3:0]        avs_address,      // Byte address
    input  wire logic              avs_read,         // Read request
    input  wire logic              avs_write,        // Write request
    input  wire logic [31:0]       avs_writedata,    // Write data
    output logic [31:0]            avs_readdata,     // Read data
    output logic                   avs_waitrequest,  // Stall
    output logic                   switchGate,       // Power switch drive
    output logic [STEP_W-1:0]      refStep,          // Reference step code
    output logic                   refChop,          // Reference chopper gate
    output logic                   shutdown          // Low-power state
);
    logic [5:0]        syncA;
    logic [5:0]        syncB;
    logic              enS;
    logic              enD;
    logic              enRise;
    lbd_fault_t        flt;
    logic              tripS;
    lbd_state_t        state;
    lbd_state_t        next_state;
    logic [CW-1:0]     offCnt;
    logic              offDone;
    logic [CW-1:0]     winCnt;
    logic [CW-1:0]     lowCnt;
    lbd_bit_t          rx;
    logic              byteIdx;
    logic              addrOk;
    logic [STEP_W-1:0] stepReg;
    logic [CW-1:0]     ssCnt;
    logic [STEP_W-1:0] ssLevel;
    logic [STEP_W-1:0] target;
    logic [7:0]        oscCnt;
    logic [3:0]        onCnt;
    logic              running;
    logic              swAllow;
    logic              offReq;
    logic [1:0]        ctrl;
    logic              ack;

    ////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for every pin
    always_ff @(posedge clk) begin
        if (reset) begin
            syncA <= '0;
            syncB <= '0;
            enD   <= 1'b0;
        end else begin
            syncA <= {enablePin, faultPins, currentTrip};
            syncB <= syncA;
            enD   <= enS;
        end
    end
    assign enS    = syncB[5];
    assign flt    = syncB[4:1];
    assign tripS  = syncB[0];
    assign enRise = enS & ~enD;

    ////////////////////////////////////////////////////////////////
    // Shutdown timer on a continuous low
    always_ff @(posedge clk) begin
        if (reset || enS)
            offCnt <= '0;
        else if (!offDone)
            offCnt <= offCnt + 1'b1;
    end
    assign offDone = !enS && offCnt >= CW'(OFF_CYC - 1);

    // Entry detection window and low-time counters
    always_ff @(posedge clk) begin
        if (reset || state != ST_DET) begin
            winCnt <= '0;
            lowCnt <= '0;
        end else begin
            winCnt <= winCnt + 1'b1;
            if (enS)
                lowCnt <= '0;
            else if (winCnt >= CW'(DLY_CYC) && lowCnt < CW'(DET_CYC))
                lowCnt <= lowCnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        unique case (state)
            ST_OFF: begin
                if (enRise && !flt.input_undervoltage_flag)
                    next_state = ST_DET;
            end
            ST_DET: begin
                if (enRise && lowCnt >= CW'(DET_CYC))
                    next_state = ST_DIG;
                else if (winCnt >= CW'(WIN_CYC - 1))
                    next_state = ST_PWM;
            end
            ST_PWM: next_state = ST_PWM;
            ST_DIG: next_state = ST_DIG;
            ST_FLT: next_state = ST_FLT;
        endcase
        if (running && flt.output_overvoltage_flag)
            next_state = ST_FLT;
        if (offDone || flt.input_undervoltage_flag)
            next_state = ST_OFF;
    end

    always_ff @(posedge clk) begin
        if (reset)
            state <= ST_OFF;
        else
            state <= next_state;
    end
    assign running  = state inside {ST_DET, ST_PWM, ST_DIG};
    assign shutdown = state inside {ST_OFF, ST_FLT};

    ////////////////////////////////////////////////////////////////
    // One-wire receiver runs only once digital mode is chosen
    lbd_bit_rx #(
        .BIT_CYC (BIT_CYC),
        .LOW_CYC (LOW_CYC)
    ) u_rx (
        .clk   (clk),
        .reset (reset),
        .run   (state == ST_DIG),
        .line  (enS),
        .rx    (rx)
    );

    // Address byte then data byte
    always_ff @(posedge clk) begin
        if (reset || state != ST_DIG || rx.abort) begin
            byteIdx <= 1'b0;
            addrOk  <= 1'b0;
        end else if (rx.byteDone) begin
            byteIdx <= ~byteIdx;
            if (!byteIdx)
                addrOk <= rx.data == DEV_ADDR;
        end
    end

    // Stored step survives shutdown; only reset or input undervoltage sets it back to STEP_FULL
    always_ff @(posedge clk) begin
        if (reset || flt.input_undervoltage_flag)
            stepReg <= STEP_FULL;
        else if (rx.byteDone && byteIdx && addrOk && rx.data[7:5] == 3'h0)
            stepReg <= rx.data[4:0];
    end

    ////////////////////////////////////////////////////////////////
    // Soft-start ramp restarts from zero on every start from shutdown
    always_ff @(posedge clk) begin
        if (reset || !running) begin
            ssCnt   <= '0;
            ssLevel <= '0;
        end else if (ssLevel != STEP_FULL) begin
            if (ssCnt >= CW'(SS_CYC / 32 - 1)) begin
                ssCnt   <= '0;
                ssLevel <= ssLevel + 1'b1;
            end else begin
                ssCnt <= ssCnt + 1'b1;
            end
        end
    end

    assign target = (state == ST_DIG) ? stepReg : STEP_FULL;

    always_ff @(posedge clk) begin
        if (reset || !running) begin
            refStep <= '0;
            refChop <= 1'b0;
        end else begin
            refStep <= (target < ssLevel) ? target : ssLevel;
            // PWM mode follows the pin, so the average tracks the duty
            refChop <= (state == ST_DIG) ? 1'b1 : enS;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Switching cycle
    always_ff @(posedge clk) begin
        if (reset || oscCnt == 8'(OSC_CYC - 1))
            oscCnt <= '0;
        else
            oscCnt <= oscCnt + 1'b1;
    end

    assign swAllow = running && !flt.otp && !flt.input_undervoltage_flag && !flt.output_overvoltage_flag && ctrl[0];
    assign offReq  = tripS || flt.switch_current_limit_flag || oscCnt == 8'(MAX_ON_CYC) || !swAllow;

    always_ff @(posedge clk) begin
        if (reset) begin
            switchGate <= 1'b0;
            onCnt      <= '0;
        end else if (!switchGate) begin
            onCnt <= '0;
            if (oscCnt == '0 && swAllow)
                switchGate <= 1'b1;
        end else begin
            if (onCnt != 4'hf)
                onCnt <= onCnt + 1'b1;
            // Even forced turn-off respects the minimum pulse
            if (offReq && onCnt >= 4'(MIN_ON_CYC - 1))
                switchGate <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Register slave; one wait cycle per access
    always_ff @(posedge clk) begin
        if (reset)
            ack <= 1'b0;
        else
            ack <= (avs_read || avs_write) && !ack;
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ack;

    always_ff @(posedge clk) begin
        if (reset)
            ctrl <= CTRL_RESET;
        else if (avs_write && !ack && avs_address == REG_CTRL_OFS)
            ctrl <= avs_writedata[1:0];
    end

    always_ff @(posedge clk) begin
        if (reset)
            avs_readdata <= '0;
        else if (avs_read && !ack) begin
            unique case (avs_address)
                REG_STATUS_OFS: avs_readdata <= {12'h0, switchGate, flt, state, stepReg, refStep};
                REG_CTRL_OFS:   avs_readdata <= {30'h0, ctrl};
                default:        avs_readdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_shut;
        offDone && !flt.input_undervoltage_flag |=> state == ST_OFF;
    endproperty
    a_shut: assert property (p_shut) else $error("no shutdown after long low");

    property p_pwm_default;
        state == ST_DET && winCnt >= CW'(WIN_CYC - 1) && !enRise && !offDone && !flt.input_undervoltage_flag
            && !flt.output_overvoltage_flag |=> state == ST_PWM;
    endproperty
    a_pwm_default: assert property (p_pwm_default) else $error("window expiry not PWM");

    property p_dig_entry;
        $rose(state == ST_DIG) |-> $past(state) == ST_DET && $past(lowCnt) >= CW'(DET_CYC);
    endproperty
    a_dig_entry: assert property (p_dig_entry) else $error("digital mode entered wrongly");

    property p_mode_kept;
        state == ST_PWM |=> state != ST_DIG;
    endproperty
    a_mode_kept: assert property (p_mode_kept) else $error("mode changed while running");

    property p_min_on;
        $fell(switchGate) |-> $past(onCnt) >= 4'(MIN_ON_CYC - 1);
    endproperty
    a_min_on: assert property (p_min_on) else $error("switch pulse too short");

    property p_gate_start;
        $rose(switchGate) |-> $past(oscCnt) == '0 ##1 switchGate[*8];
    endproperty
    a_gate_start: assert property (p_gate_start) else $error("switch set off oscillator");

    property p_climit;
        switchGate && flt.switch_current_limit_flag && onCnt >= 4'(MIN_ON_CYC - 1) |=> !switchGate;
    endproperty
    a_climit: assert property (p_climit) else $error("current limit ignored");

    property p_ovp;
        running && flt.output_overvoltage_flag && !offDone && !flt.input_undervoltage_flag |=> state == ST_FLT ##[1:10] !switchGate;
    endproperty
    a_ovp: assert property (p_ovp) else $error("over-voltage not shut down");

    property p_otp;
        flt.otp && !switchGate |=> !switchGate;
    endproperty
    a_otp: assert property (p_otp) else $error("switching while hot");

    property p_input_undervoltage_flag;
        flt.input_undervoltage_flag |=> state == ST_OFF && stepReg == STEP_FULL;
    endproperty
    a_input_undervoltage_flag: assert property (p_input_undervoltage_flag) else $error("undervoltage not honoured");

    property p_discard;
        rx.byteDone && byteIdx && !addrOk |=> $stable(stepReg);
    endproperty
    a_discard: assert property (p_discard) else $error("bad command stored");

    property p_ramp;
        refStep <= ssLevel;
    endproperty
    a_ramp: assert property (p_ramp) else $error("reference above ramp");

    c_digital: cover property ($rose(state == ST_DIG));
    c_pwm:     cover property ($rose(state == ST_PWM));
    c_store:   cover property (rx.byteDone && byteIdx && addrOk ##1 stepReg != STEP_FULL);
    c_fault:   cover property ($rose(state == ST_FLT));
endmodule

// ### testbench/lbd_host_model.sv
`timescale 1ns/10ps
module lbd_host_model (
    input  wire logic clk,       // Core clock
    output logic      enablePin  // Enable line to the device
);
    // Short half just over 3 us, long half over twice it
    localparam int SHORT = 752;
    localparam int LONG  = 1510;

    initial enablePin = 1'b0;

    ////////////////////////////////////////////////////////////////
    // Every hold ends at a falling edge, so callers sample settled
    task automatic hold(input logic lvl, input int n);
        @(posedge clk);
        enablePin <= lvl;
        repeat (n) @(negedge clk);
    endtask

    task automatic enterDigital;
        hold(1'b1, 150);
        hold(1'b0, 300);
        hold(1'b1, 20);
    endtask

    task automatic sendByte(input logic [7:0] b);
        hold(1'b1, 800);
        for (int i = 7; i >= 0; i--) begin
            if (b[i]) begin
                hold(1'b0, SHORT);
                hold(1'b1, LONG);
            end else begin
                hold(1'b0, LONG);
                hold(1'b1, SHORT);
            end
        end
        hold(1'b0, 800);
    endtask

    // Address byte then data byte; line left high afterwards
    task automatic sendCmd(input logic [7:0] addr, input logic [7:0] data);
        sendByte(addr);
        sendByte(data);
        hold(1'b1, 50);
    endtask
endmodule

// ### testbench/lbd_core_tb.sv
`timescale 1ns/10ps
module lbd_core_tb import lbd_pkg::*; ;
    logic              clk = 1'b0;
    logic              reset = 1'b1;
    logic              enablePin;
    lbd_fault_t        faultPins = '0;
    logic              currentTrip = 1'b0;
    logic [3:0]        avs_address = 4'h0;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [31:0]       avs_writedata = 32'h0;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic              switchGate;
    logic [STEP_W-1:0] refStep;
    logic              refChop;
    logic              shutdown;
    logic [31:0]       q;
    int                hi;
    int                errorCnt = 0;
    int                checks = 0;

    always #2 clk = ~clk;

    // Mode and ramp counts shortened; bit limits keep their full values
    lbd_core #(.OFF_CYC(3000), .WIN_CYC(1000), .DLY_CYC(100), .DET_CYC(260),
        .SS_CYC(320)) lbd_core_inst (
        .clk(clk), .reset(reset), .enablePin(enablePin), .faultPins(faultPins),
        .currentTrip(currentTrip), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .switchGate(switchGate), .refStep(refStep),
        .refChop(refChop), .shutdown(shutdown));

    lbd_host_model lbd_host_model_inst (.clk(clk), .enablePin(enablePin));

    ////////////////////////////////////////////////////////////////
    task automatic endOfTest;
        $display("Mismatches %0d, comparisons %0d", errorCnt, checks);
        if (errorCnt == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // Request held up to the rising edge that sees waitrequest low
    task automatic busAccess(input logic wr, input logic [3:0] a, input logic [31:0] d,
                             output logic [31:0] rd);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 50) begin
                errorCnt++;
                $display("CHECK FAILED %0t bus answer missing", $time);
                endOfTest;
            end
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(negedge clk);
    endtask

    task automatic chkStatus(input lbd_state_t st, input logic [4:0] step);
        logic [31:0] rd;
        busAccess(1'b0, REG_STATUS_OFS, 32'h0, rd);
        chkWord({22'h0, rd[14:5]}, {22'h0, st, step});
    endtask

    task automatic waitGate(input logic lvl, input int bound);
        int n;
        n = 0;
        while (switchGate !== lvl && n < bound) begin
            @(negedge clk);
            n++;
        end
        chkBit(switchGate, lvl);
        if (switchGate !== lvl)
            endOfTest;
    endtask

    task automatic cntGate(input int n, output int cnt);
        cnt = 0;
        repeat (n) begin
            @(negedge clk);
            if (switchGate === 1'b1)
                cnt++;
        end
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (95000) @(posedge clk);
        errorCnt++;
        $display("CHECK FAILED %0t run too long", $time);
        endOfTest;
    end

    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chkBit(shutdown, 1'b1);
        chkStatus(ST_OFF, STEP_FULL);
        busAccess(1'b0, REG_CTRL_OFS, 32'h0, q);
        chkWord(q, 32'h1);
        busAccess(1'b0, 4'h8, 32'h0, q);
        chkWord(q, 32'h0);
        lbd_host_model_inst.hold(1'b1, 20);
        chkBit(refStep < 5'h08, 1'b1);
        // Low too short for entry, so PWM by default
        lbd_host_model_inst.hold(1'b1, 130);
        lbd_host_model_inst.hold(1'b0, 200);
        lbd_host_model_inst.hold(1'b1, 1100);
        chkStatus(ST_PWM, STEP_FULL);
        chkWord({27'h0, refStep}, 32'h1f);
        chkBit(refChop, 1'b1);
        lbd_host_model_inst.hold(1'b0, 300);
        chkBit(refChop, 1'b0);
        chkBit(shutdown, 1'b0);
        lbd_host_model_inst.hold(1'b1, 20);
        chkStatus(ST_PWM, STEP_FULL);
        // Catch a fresh rise so the first 100 cycles of one on-time are counted
        waitGate(1'b0, 250);
        waitGate(1'b1, 250);
        cntGate(100, hi);
        chkWord(32'(hi), 32'd100);
        @(posedge clk);
        currentTrip <= 1'b1;
        waitGate(1'b0, 8);
        waitGate(1'b1, 250);
        cntGate(40, hi);
        chkBit(hi >= MIN_ON_CYC - 1 && hi <= MIN_ON_CYC + 2, 1'b1);
        @(posedge clk);
        currentTrip <= 1'b0;
        faultPins.switch_current_limit_flag <= 1'b1;
        waitGate(1'b1, 260);
        cntGate(40, hi);
        chkBit(hi >= MIN_ON_CYC - 1 && hi <= MIN_ON_CYC + 2, 1'b1);
        @(posedge clk);
        faultPins.switch_current_limit_flag <= 1'b0;
        faultPins.otp <= 1'b1;
        waitGate(1'b0, 20);
        cntGate(300, hi);
        chkWord(32'(hi), 32'd0);
        @(posedge clk);
        faultPins.otp <= 1'b0;
        waitGate(1'b1, 260);
        busAccess(1'b1, REG_CTRL_OFS, 32'h2, q);
        busAccess(1'b0, REG_CTRL_OFS, 32'h0, q);
        chkWord(q, 32'h2);
        waitGate(1'b0, 20);
        cntGate(300, hi);
        chkWord(32'(hi), 32'd0);
        busAccess(1'b1, REG_CTRL_OFS, 32'h1, q);
        waitGate(1'b1, 260);
        @(posedge clk);
        faultPins.output_overvoltage_flag <= 1'b1;
        repeat (16) @(negedge clk);
        chkBit(shutdown, 1'b1);
        chkBit(switchGate, 1'b0);
        @(posedge clk);
        faultPins.output_overvoltage_flag <= 1'b0;
        lbd_host_model_inst.hold(1'b1, 50);
        chkStatus(ST_FLT, STEP_FULL);
        lbd_host_model_inst.hold(1'b0, 2950);
        chkStatus(ST_FLT, STEP_FULL);
        lbd_host_model_inst.hold(1'b0, 100);
        chkStatus(ST_OFF, STEP_FULL);
        lbd_host_model_inst.enterDigital();
        chkStatus(ST_DIG, STEP_FULL);
        chkBit(refChop, 1'b1);
        lbd_host_model_inst.sendCmd(DEV_ADDR, 8'h0a);
        chkStatus(ST_DIG, 5'h0a);
        chkWord({27'h0, refStep}, 32'h0a);
        // Address off in its first bit, so a lost first bit shows
        lbd_host_model_inst.sendCmd(8'hf2, 8'h05);
        chkStatus(ST_DIG, 5'h0a);
        @(posedge clk);
        faultPins.input_undervoltage_flag <= 1'b1;
        repeat (16) @(negedge clk);
        chkBit(shutdown, 1'b1);
        chkBit(switchGate, 1'b0);
        chkStatus(ST_OFF, STEP_FULL);
        endOfTest;
    end
endmodule
